/* hdl/psc_pkg.sv */
// constants and types shared by the passive serial configuration port
package psc_pkg;

    localparam int CLK_MHZ           = 125;
    localparam int STATUS_MIN_US     = 10;
    localparam int STATUS_MIN_CYC    = STATUS_MIN_US * CLK_MHZ;
    localparam int POR_DELAY_US      = 100;
    localparam int POR_DELAY_CYC     = POR_DELAY_US * CLK_MHZ;
    localparam int INIT_MIN_US       = 55;
    localparam int INIT_MIN_CYC      = INIT_MIN_US * CLK_MHZ;
    localparam int UCLK_INIT_PERIODS = 8532;
    localparam int INIT_FALL_EDGES   = 2;
    localparam int IMAGE_BITS_DEF    = 1024;
    localparam int CNT_W             = 16;
    localparam int BIT_CNT_W         = 32;
    localparam int BYTE_W            = 8;
    localparam int FIFO_DEPTH        = 16;

    // positions inside the synchronised pin vector
    localparam int SYNC_W      = 7;
    localparam int SYNC_REQ    = 0;
    localparam int SYNC_STATUS = 1;
    localparam int SYNC_DONE   = 2;
    localparam int SYNC_CE     = 3;
    localparam int SYNC_SCLK   = 4;
    localparam int SYNC_SDATA  = 5;
    localparam int SYNC_UCLK   = 6;

    typedef enum logic [8:0] {
        PSC_POR      = 9'h001,
        PSC_CLEAR    = 9'h002,
        PSC_WAIT_CE  = 9'h004,
        PSC_LOAD     = 9'h008,
        PSC_WAIT_DN  = 9'h010,
        PSC_INIT_SYN = 9'h020,
        PSC_INIT     = 9'h040,
        PSC_USER     = 9'h080,
        PSC_ERROR    = 9'h100
    } psc_state_e;

endpackage

/* hdl/psc_sync.sv */
// two-stage synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module psc_sync #(
    parameter int          WIDTH = 1,
    parameter logic [63:0] INIT  = 64'h0
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stage1   <= INIT[WIDTH-1:0];
            sync_out <= INIT[WIDTH-1:0];
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // psc_sync
`default_nettype wire

/* hdl/psc_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module psc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // psc_fifo
`default_nettype wire

/* hdl/psc_config_port.sv */
// passive serial configuration port, device side
//
// Function
// R01: one bit taken per shift clock rise
// R02: host sends each byte LSB first
// R03: host clocks until complete line rises
// R04: user mode keeps lines high; request restarts
// R05: status held low during power-on delay
// R06: complete low from power-up through loading
// R07: complete and status low within 800 ns
// R08: host holds request low 2 us minimum
// R09: status low pulse 10 to 500 us
// R10: status released within 500 us after request
// R11: host waits 500 us before first clock
// R12: host waits 2 us after status high
// R13: two falling clock edges start initialisation
// R14: oscillator init: user mode 55-150 us
// R15: user init clock: enable, then 8532 periods
// R16: finished device drives chain output low
// R17: wired complete line gates joint user entry
// R18: error pulls status low, halts chain
// R19: tied chain inputs load concurrently, together
// R20: host keeps shift clock driven afterwards
// R21: serial data pin stays dedicated
// R22: unchained chain output may stay unused
// R23: host watches status, restarts on fall
`timescale 1ns/1ps
`default_nettype none
module psc_config_port #(
    parameter int IMAGE_BITS   = psc_pkg::IMAGE_BITS_DEF,
    parameter int POR_CYC      = psc_pkg::POR_DELAY_CYC,
    parameter int INIT_CYC     = psc_pkg::INIT_MIN_CYC,
    parameter int UCLK_PERIODS = psc_pkg::UCLK_INIT_PERIODS
) (
    input  wire logic                       clock,
    input  wire logic                       resetn,
    input  wire logic                       config_request_n,
    input  wire logic                       config_status_n_in,
    output logic                            config_status_n_out,
    output logic                            config_status_n_oe_n,
    input  wire logic                       config_complete_in,
    output logic                            config_complete_out,
    output logic                            config_complete_oe_n,
    input  wire logic                       chain_enable_in_n,
    output logic                            chain_enable_out_n,
    input  wire logic                       config_serial_in,
    input  wire logic                       config_shift_clock,
    input  wire logic                       user_init_clock,
    input  wire logic                       user_init_clock_option,
    input  wire logic                       config_error,
    output logic [psc_pkg::BYTE_W-1:0]      cfg_byte,
    output logic                            cfg_byte_valid,
    input  wire logic                       cfg_byte_ready,
    output logic                            init_clock_enabled,
    output logic                            user_mode
);
    import psc_pkg::*;

    psc_state_e             state;
    psc_state_e             next_state;
    logic [SYNC_W-1:0]      pins;
    logic                   sclk_prev;
    logic                   uclk_prev;
    logic                   sclk_rise;
    logic                   sclk_fall;
    logic                   uclk_rise;
    logic                   req_low;
    logic [CNT_W-1:0]       cnt;
    logic                   cnt_inc;
    logic [BIT_CNT_W-1:0]   bit_cnt;
    logic [BYTE_W-1:0]      shreg;
    logic [2:0]             bit_idx;
    logic [BYTE_W-1:0]      push_data;
    logic                   push_valid;
    logic                   push_ready;
    logic                   overflow;
    logic                   last_bit;

    // pins cross into the clock domain; idle levels are high except the chain enable
    psc_sync #(
        .WIDTH (SYNC_W),
        .INIT  (64'h0000_0000_0000_0077)
    ) u_sync (
        .clock    (clock),
        .resetn   (resetn),
        .async_in ({user_init_clock, config_serial_in, config_shift_clock,
                    chain_enable_in_n, config_complete_in, config_status_n_in,
                    config_request_n}),
        .sync_out (pins)
    );

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclk_prev <= 1'b1;
            uclk_prev <= 1'b1;
        end else begin
            sclk_prev <= pins[SYNC_SCLK];
            uclk_prev <= pins[SYNC_UCLK];
        end
    end

    // R01 edge detect
    assign sclk_rise = pins[SYNC_SCLK] && !sclk_prev;
    assign sclk_fall = !pins[SYNC_SCLK] && sclk_prev;
    assign uclk_rise = pins[SYNC_UCLK] && !uclk_prev;
    assign req_low   = !pins[SYNC_REQ];
    assign last_bit  = (bit_cnt == BIT_CNT_W'(IMAGE_BITS - 1));
    assign overflow  = push_valid && !push_ready;

    always_comb begin
        next_state = state;
        unique case (state)
            // R05 power-on hold
            PSC_POR: begin
                if (cnt >= CNT_W'(POR_CYC - 1)) begin
                    next_state = PSC_CLEAR;
                end
            end
            // R09 minimum pulse, stretched by request
            PSC_CLEAR: begin
                if (cnt >= CNT_W'(STATUS_MIN_CYC - 1) && !req_low) begin
                    next_state = PSC_WAIT_CE;
                end
            end
            // R16 chain enable gates loading
            PSC_WAIT_CE: begin
                if (pins[SYNC_STATUS] && !pins[SYNC_CE]) begin
                    next_state = PSC_LOAD;
                end
            end
            // R18 own or external error halts
            PSC_LOAD: begin
                if (!pins[SYNC_STATUS] || config_error || overflow) begin
                    next_state = PSC_ERROR;
                end else if (sclk_rise && last_bit) begin
                    next_state = PSC_WAIT_DN;
                end
            end
            // R17 wait for every device to release
            PSC_WAIT_DN: begin
                if (!pins[SYNC_STATUS] || config_error) begin
                    next_state = PSC_ERROR;
                end else if (pins[SYNC_DONE]) begin
                    next_state = PSC_INIT_SYN;
                end
            end
            // R13 two falling edges
            PSC_INIT_SYN: begin
                if (cnt >= CNT_W'(INIT_FALL_EDGES)) begin
                    next_state = PSC_INIT;
                end
            end
            // R14 R15 initialisation length
            PSC_INIT: begin
                if (user_init_clock_option) begin
                    if (cnt >= CNT_W'(UCLK_PERIODS)) begin
                        next_state = PSC_USER;
                    end
                end else if (cnt >= CNT_W'(INIT_CYC - 1)) begin
                    next_state = PSC_USER;
                end
            end
            PSC_USER: begin
                next_state = PSC_USER;
            end
            PSC_ERROR: begin
                next_state = PSC_ERROR;
            end
            default: begin
                next_state = PSC_CLEAR;
            end
        endcase
        // R04 R07 request low restarts from any state after power-on
        if (req_low && state != PSC_POR && state != PSC_CLEAR) begin
            next_state = PSC_CLEAR;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= PSC_POR;
        end else begin
            state <= next_state;
        end
    end

    // one counter, its event chosen by the state
    always_comb begin
        unique case (state)
            PSC_INIT_SYN: cnt_inc = sclk_fall;
            PSC_INIT:     cnt_inc = user_init_clock_option ? uclk_rise : 1'b1;
            default:      cnt_inc = 1'b1;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt <= '0;
        end else if (next_state != state) begin
            cnt <= '0;
        end else if (cnt_inc && cnt != '1) begin
            cnt <= cnt + 1'b1;
        end
    end

    // R01 R02 R21 bits shifted in LSB first
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            shreg   <= '0;
            bit_idx <= '0;
            bit_cnt <= '0;
        end else if (state != PSC_LOAD) begin
            bit_idx <= '0;
            bit_cnt <= '0;
        end else if (sclk_rise) begin
            shreg   <= {pins[SYNC_SDATA], shreg[BYTE_W-1:1]};
            bit_idx <= bit_idx + 1'b1;
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            push_valid <= 1'b0;
            push_data  <= '0;
        end else begin
            push_valid <= (state == PSC_LOAD) && sclk_rise && (bit_idx == 3'h7);
            if (sclk_rise && bit_idx == 3'h7) begin
                push_data <= {pins[SYNC_SDATA], shreg[BYTE_W-1:1]};
            end
        end
    end

    // a full fifo cannot stall the host, so it counts as an error
    psc_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .resetn    (resetn),
        .in_data   (push_data),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .out_data  (cfg_byte),
        .out_valid (cfg_byte_valid),
        .out_ready (cfg_byte_ready)
    );

    // R15 enable user init clock as the state enters PSC_INIT_SYN, before the two falling edges
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            init_clock_enabled <= 1'b0;
        end else begin
            init_clock_enabled <= user_init_clock_option &&
                                  (next_state == PSC_INIT || next_state == PSC_INIT_SYN);
        end
    end

    // open-drain lines: value is always low, enable low means pulling
    assign config_status_n_out  = 1'b0;
    assign config_complete_out  = 1'b0;

    // pin controls come from flops: a decode of two one-hot bits may glitch
    // on a state change and pull a wired line that other devices watch
    // R05 R07 R09 R10 R18 status pulled in reset pulse and after error
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            config_status_n_oe_n <= 1'b0;
        end else begin
            config_status_n_oe_n <= !(next_state == PSC_POR || next_state == PSC_CLEAR ||
                                      next_state == PSC_ERROR);
        end
    end

    // R06 R07 R17 complete released only once this image is in
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            config_complete_oe_n <= 1'b0;
        end else begin
            config_complete_oe_n <= (next_state == PSC_WAIT_DN ||
                                     next_state == PSC_INIT_SYN ||
                                     next_state == PSC_INIT ||
                                     next_state == PSC_USER);
        end
    end

    // R16 R19 R22 chain output low once this device is loaded
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            chain_enable_out_n <= 1'b1;
        end else begin
            chain_enable_out_n <= !(next_state == PSC_WAIT_DN ||
                                    next_state == PSC_INIT_SYN ||
                                    next_state == PSC_INIT ||
                                    next_state == PSC_USER);
        end
    end

    // R04 user mode
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            user_mode <= 1'b0;
        end else begin
            user_mode <= (next_state == PSC_USER);
        end
    end

endmodule // psc_config_port
`default_nettype wire

/* testbench/psc_config_port_assertions.sv */
// concurrent checks on the configuration port pins
`timescale 1ns/1ps
`default_nettype none
module psc_config_port_checker
    import psc_pkg::*;
#(
    parameter int INIT_CYC = 40
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic config_request_n,
    input wire logic config_status_n_in,
    input wire logic config_status_n_oe_n,
    input wire logic config_complete_in,
    input wire logic config_complete_oe_n,
    input wire logic chain_enable_in_n,
    input wire logic chain_enable_out_n,
    input wire logic user_init_clock_option,
    input wire logic config_error,
    input wire logic init_clock_enabled,
    input wire logic user_mode
);
    logic [15:0] low_cycles;
    logic [15:0] done_cycles;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // saturating counts, so a long hold never wraps to a false short pulse
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            low_cycles  <= '0;
            done_cycles <= '0;
        end else begin
            low_cycles  <= config_status_n_oe_n ? '0 : low_cycles + {15'h0, ~&low_cycles};
            done_cycles <= !config_complete_in ? '0 : done_cycles + {15'h0, ~&done_cycles};
        end
    end
    req_pulls_lines_a: assert property (
        $fell(config_request_n) |-> ##[1:100] (!config_status_n_oe_n && !config_complete_oe_n))
        else $error("lines not pulled after request fall");
    status_pulse_min_a: assert property (
        $rose(config_status_n_oe_n) |-> low_cycles >= STATUS_MIN_CYC)
        else $error("status low pulse too short");
    complete_gated_a: assert property (
        config_complete_oe_n |-> !chain_enable_out_n && config_status_n_oe_n)
        else $error("complete released before image loaded");
    chain_with_done_a: assert property (
        $rose(config_complete_oe_n) |-> $fell(chain_enable_out_n))
        else $error("chain output not low with complete");
    user_waits_line_a: assert property (
        $rose(user_mode) |-> $past(config_complete_in))
        else $error("user mode while complete line low");
    init_min_time_a: assert property (
        $rose(user_mode) && !user_init_clock_option |-> done_cycles >= INIT_CYC)
        else $error("user mode too early");
    uclk_enable_a: assert property (
        $rose(config_complete_in) && user_init_clock_option |-> ##[1:32] init_clock_enabled)
        else $error("user init clock not enabled");
    error_pulls_a: assert property (
        config_error && config_status_n_oe_n && chain_enable_out_n && !chain_enable_in_n
        && $past(config_status_n_in, 4) |-> ##[1:4] !config_status_n_oe_n)
        else $error("error did not pull status");
    user_lines_high_a: assert property (
        user_mode |-> config_status_n_oe_n && config_complete_oe_n)
        else $error("line pulled in user mode");
endmodule // psc_config_port_checker
bind psc_config_port psc_config_port_checker #(.INIT_CYC(INIT_CYC)) port_chk (
    .clock(clock), .resetn(resetn), .config_request_n(config_request_n),
    .config_status_n_in(config_status_n_in), .config_status_n_oe_n(config_status_n_oe_n),
    .config_complete_in(config_complete_in), .config_complete_oe_n(config_complete_oe_n),
    .chain_enable_in_n(chain_enable_in_n), .chain_enable_out_n(chain_enable_out_n),
    .user_init_clock_option(user_init_clock_option), .config_error(config_error),
    .init_clock_enabled(init_clock_enabled), .user_mode(user_mode));
`default_nettype wire

/* testbench/psc_host_model.sv */
// host that shifts configuration bytes into the port
`timescale 1ns/1ps
`default_nettype none
module psc_host_model #(
    parameter int WAIT_NS = 2000
) (
    input  wire logic status_line,
    output var  logic shift_clock,
    output var  logic serial_data
);
    initial begin
        shift_clock = 1'b0;
        serial_data = 1'b0;
    end
    task automatic prepare();
        wait (status_line === 1'b1);
        #(WAIT_NS);
    endtask
    task automatic send_byte(input logic [7:0] b);
        #3;
        for (int i = 0; i < 8; i++) begin
            // stop once status is pulled low
            if (status_line !== 1'b1) return;
            // lsb first, one bit per rise
            serial_data = b[i];
            #32 shift_clock = 1'b1;
            // past hold the old bit is gone, before the fall
            #16 serial_data = ~b[i];
            #16 shift_clock = 1'b0;
        end
    endtask
    task automatic fall_edges(input int n);
        for (int i = 0; i < n; i++) begin
            #32 shift_clock = 1'b1;
            #32 shift_clock = 1'b0;
        end
    endtask
endmodule // psc_host_model
`default_nettype wire

/* testbench/test_psc_config_port.sv */
// self-checking bench for the passive serial configuration port
`timescale 1ns/1ps
`default_nettype none
module test_psc_config_port;
    import psc_pkg::*;
    localparam int INIT_CYC = 40;
    logic       clock, resetn, config_request_n, ext_done_low, user_init_clock;
    logic       user_init_clock_option, config_error, cfg_byte_ready, chain_in_n;
    logic       status_line, complete_line, shift_clock, serial_data;
    logic       config_status_n_out, config_status_n_oe_n, config_complete_out;
    logic       config_complete_oe_n, chain_enable_out_n, cfg_byte_valid;
    logic       init_clock_enabled, user_mode;
    logic [7:0] cfg_byte;
    int         mismatches, checks_done, cycles;
    // sent byte beside the byte expected at the fifo head
    logic [15:0] rows [4] = '{16'h0202, 16'h1B1B, 16'hEEEE, 16'h0101};
    // pull-ups on both wired lines
    assign status_line   = config_status_n_oe_n ? 1'b1 : config_status_n_out;
    assign complete_line = (config_complete_oe_n ? 1'b1 : config_complete_out) & ~ext_done_low;
    psc_config_port #(.IMAGE_BITS(32), .POR_CYC(50), .INIT_CYC(INIT_CYC), .UCLK_PERIODS(10)) uut (
        .clock(clock), .resetn(resetn), .config_request_n(config_request_n),
        .config_status_n_in(status_line), .config_status_n_out(config_status_n_out),
        .config_status_n_oe_n(config_status_n_oe_n), .config_complete_in(complete_line),
        .config_complete_out(config_complete_out), .config_complete_oe_n(config_complete_oe_n),
        .chain_enable_in_n(chain_in_n), .chain_enable_out_n(chain_enable_out_n),
        .config_serial_in(serial_data), .config_shift_clock(shift_clock),
        .user_init_clock(user_init_clock), .user_init_clock_option(user_init_clock_option),
        .config_error(config_error), .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
        .cfg_byte_ready(cfg_byte_ready), .init_clock_enabled(init_clock_enabled),
        .user_mode(user_mode));
    psc_host_model host (.status_line(status_line), .shift_clock(shift_clock),
        .serial_data(serial_data));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        user_init_clock = 1'b0;
        forever #20 user_init_clock = ~user_init_clock;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_status();
        for (int i = 0; i < 3000 && status_line !== 1'b1; i++) @(negedge clock);
        cmp("status_line", 8'h01, status_line);
    endtask
    // bytes pile up in the fifo while the consumer stalls, then drain
    task automatic load_image();
        host.prepare();
        foreach (rows[i]) host.send_byte(rows[i][15:8]);
        @(negedge clock);
        for (int i = 0; i < 100 && config_complete_oe_n !== 1'b1; i++) @(negedge clock);
        cmp("complete_oe_n", 8'h01, config_complete_oe_n);
        cmp("chain_out_n", 8'h00, chain_enable_out_n);
        foreach (rows[i]) begin
            cmp("cfg_byte", rows[i][7:0], cfg_byte);
            cfg_byte_ready = 1'b1;
            @(negedge clock);
            cfg_byte_ready = 1'b0;
            @(negedge clock);
        end
        cmp("cfg_byte_valid", 8'h00, cfg_byte_valid);
    endtask
    task automatic finish_init();
        repeat (50) @(negedge clock);
        cmp("user_mode held", 8'h00, user_mode);
        ext_done_low = 1'b0;
        repeat (60) @(negedge clock);
        cmp("user_mode no edges", 8'h00, user_mode);
        host.fall_edges(2);
        cmp("init_clk_en", {7'h00, user_init_clock_option}, init_clock_enabled);
        for (int i = 0; i < 600 && user_mode !== 1'b1; i++) @(negedge clock);
        cmp("user_mode", 8'h01, user_mode);
        cmp("status user", 8'h01, status_line);
        cmp("complete user", 8'h01, complete_line);
    endtask
    task automatic reconfig();
        config_request_n = 1'b0;
        ext_done_low = 1'b1;
        repeat (100) @(negedge clock);
        cmp("status_oe_n", 8'h00, config_status_n_oe_n);
        cmp("complete_oe_n", 8'h00, config_complete_oe_n);
        cmp("user_mode", 8'h00, user_mode);
        repeat (160) @(negedge clock);
        config_request_n = 1'b1;
        wait_status();
    endtask
    initial begin
        {resetn, config_error, cfg_byte_ready, user_init_clock_option} = 4'h0;
        {config_request_n, ext_done_low, chain_in_n} = 3'h7;
        repeat (5) @(negedge clock);
        cmp("status_oe_n rst", 8'h00, config_status_n_oe_n);
        cmp("complete_oe_n rst", 8'h00, config_complete_oe_n);
        cmp("chain_out_n rst", 8'h01, chain_enable_out_n);
        cmp("valid rst", 8'h00, cfg_byte_valid);
        resetn = 1'b1;
        repeat (40) @(negedge clock);
        cmp("status por", 8'h00, status_line);
        wait_status();
        $display("test reset done");
        // chain input high: these bits belong to an earlier device
        host.prepare();
        host.send_byte(8'h5A);
        @(negedge clock);
        cmp("chain held", 8'h01, chain_enable_out_n);
        cmp("valid chain", 8'h00, cfg_byte_valid);
        chain_in_n = 1'b0;
        $display("test chain gate done");
        load_image();
        finish_init();
        $display("test oscillator init done");
        reconfig();
        user_init_clock_option = 1'b1;
        load_image();
        finish_init();
        $display("test user clock init done");
        reconfig();
        user_init_clock_option = 1'b0;
        host.prepare();
        @(negedge clock);
        config_error = 1'b1;
        @(negedge clock);
        config_error = 1'b0;
        repeat (10) @(negedge clock);
        cmp("status error", 8'h00, status_line);
        host.send_byte(8'hA5);
        @(negedge clock);
        cmp("valid error", 8'h00, cfg_byte_valid);
        reconfig();
        load_image();
        finish_init();
        $display("test error restart done");
        final_report();
    end
endmodule // test_psc_config_port
`default_nettype wire
